// ===== upfs_top.sv
// port fault supervisor: debounce, attach reset, retry and current advert
// assumes comparator levels and strap inputs synchronous to core_clk_i
//
// Contract
// (R1) strap low: advertise 1.5A always, also during hold-up discharge.
// (R2) strap high: advertise 3.0A, fall back to 1.5A during discharge.
// (R3) ground short held past 250us opens the power switch.
// (R4) after ground short, retry every 2s; restore 2s after it clears.
// (R5) overvoltage held past 1ms opens the power switch.
// (R6) after overvoltage, retry every 2s; re-enable 2s after it clears.
// (R7) shield comparator above 150mV signals a shield fault.
// (R8) shield fault: reset attach logic, wait 4us, drive ground gate low.
// (R9) ground switch back on only after shield sense falls below 150mV.
// (R10) shield clear: ground switch at once, attach logic held for retry.
// (R11) forward overcurrent held 50ms turns the power switch off.
// (R12) severe short current held 250us turns the power switch off.
// (R13) after either overcurrent, keep switch off 2s before enabling.
// (R14) overtemperature held past 100us shuts the port down.
// (R15) recover only after below-135 indication held past 100us.
// (R16) every fault resets attach logic; recovery waits retry time.
// (R17) power switch off until hold-up supply is above lockout.
// (R18) switch closes only with valid sink pull-down on a CC pin.
// (R19) comparators synchronised; debounce restarts on early deassert.
// (R20) fault latched during retry; retry restarts if fault returns.
`timescale 1ns/1ps
`include "upfs_cfg.svh"
module upfs_top #(
    parameter int RETRY_CYCLES = `UPFS_CYC_RETRY,
    parameter int FWD_CYCLES   = `UPFS_CYC_FWD
) (
    input  wire logic core_clk_i,
    input  wire logic rst_i,
    input  wire logic ce_i,
    input  wire logic current_level_select_i,
    input  wire logic holdup_discharge_i,
    input  wire logic holdup_above_lockout_i,
    input  wire logic sink_attached_i,
    input  wire logic short_to_ground_i,
    input  wire logic overvoltage_i,
    input  wire logic shield_sense_i,
    input  wire logic forward_current_i,
    input  wire logic severe_short_i,
    input  wire logic overtemp_i,
    input  wire logic below_recover_temp_i,
    output logic      power_switch_o,
    output logic      attach_reset_o,
    output logic      ground_switch_gate_o,
    output logic      high_current_advert_o,
    output logic      low_current_advert_o,
    output logic      fault_active_o
);
    import upfs_pkg::*;

    // ------------------------------------------------------------
    // debounced fault indications
    // ------------------------------------------------------------
    localparam int NF = `UPFS_NUM_FAULTS;
    logic [NF-1:0] raw;
    logic [NF-1:0] deb;
    logic          cool_ok;
    logic          shield_hi;

    assign raw[`UPFS_F_SHORT]    = short_to_ground_i;
    assign raw[`UPFS_F_OVERVOLT] = overvoltage_i;
    assign raw[`UPFS_F_SHIELD]   = shield_sense_i;
    assign raw[`UPFS_F_FWD]      = forward_current_i;
    assign raw[`UPFS_F_SEVERE]   = severe_short_i;
    assign raw[`UPFS_F_THERM]    = overtemp_i;

    genvar gi;
    generate
        for (gi = 0; gi < NF; gi = gi + 1)
        begin : g_deb
            localparam int CYC =
                (gi == `UPFS_F_SHORT)    ? `UPFS_CYC_SHORT :
                (gi == `UPFS_F_OVERVOLT) ? `UPFS_CYC_OVERVOLT :
                (gi == `UPFS_F_SHIELD)   ? `UPFS_CYC_SHIELD :
                (gi == `UPFS_F_FWD)      ? FWD_CYCLES :
                (gi == `UPFS_F_SEVERE)   ? `UPFS_CYC_SEVERE :
                                           `UPFS_CYC_THERM;
            upfs_debounce #(
                .CYCLES (CYC)
            ) u_deb (
                .core_clk_i (core_clk_i),
                .rst_i      (rst_i),
                .ce_i       (ce_i),
                .raw_i      (raw[gi]), // R3 R5 R7 R11 R12 R14
                .level_o    (deb[gi])
            );
        end
    endgenerate

    // recovery from thermal shutdown needs its own held-cool filter
    upfs_debounce #(
        .CYCLES (`UPFS_CYC_THERM)
    ) u_cool (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .ce_i       (ce_i),
        .raw_i      (below_recover_temp_i), // R15
        .level_o    (cool_ok)
    );

    // ------------------------------------------------------------
    // fault latch, retry timer and attach control
    // ------------------------------------------------------------
    upfs_state_t st_r;
    upfs_state_t st_nxt;
    logic [31:0] retry_r;
    logic [31:0] retry_nxt;
    logic [31:0] gate_cnt_r;
    logic [31:0] gate_cnt_nxt;
    logic        therm_r;
    logic        therm_nxt;
    logic        shield_r;
    logic        shield_nxt;
    logic        gate_r;
    logic        gate_nxt;
    logic        sw_r;
    logic        sw_nxt;
    logic        arst_r;
    logic        arst_nxt;
    logic        hi_r;
    logic        hi_nxt;
    logic        lo_r;
    logic        lo_nxt;
    logic        flt_r;
    logic        flt_nxt;
    logic        any_fault;
    logic        cond_present;

    assign shield_hi    = shield_sense_i;
    assign any_fault    = |deb;
    // thermal holds until the cool filter passes
    assign cond_present = (|deb) | therm_r | shield_hi;

    // ------------------------------------------------------------
    // thermal latch
    // ------------------------------------------------------------
    always_comb
    begin
        therm_nxt = therm_r;
        if (deb[`UPFS_F_THERM])
            therm_nxt = 1'b1; // R14
        else if (therm_r && cool_ok)
            therm_nxt = 1'b0; // R15
    end

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            therm_r <= 1'b0;
        end
        else if (ce_i)
        begin
            therm_r <= therm_nxt;
        end
    end

    // ------------------------------------------------------------
    // shield latch and ground switch gate
    // ------------------------------------------------------------
    // gate drops only after the attach reset has had its head start
    always_comb
    begin
        shield_nxt   = shield_r;
        gate_nxt     = gate_r;
        gate_cnt_nxt = gate_cnt_r;
        if (deb[`UPFS_F_SHIELD])
            shield_nxt = 1'b1; // R8
        if (shield_r && gate_r)
        begin
            if (gate_cnt_r >= 32'(`UPFS_CYC_GATE_DELAY - 1))
                gate_nxt = 1'b0; // R8
            else
                gate_cnt_nxt = gate_cnt_r + 32'h1;
        end
        // raw level too, so a fresh rise keeps the gate off
        if (shield_r && !gate_r && !shield_hi && !deb[`UPFS_F_SHIELD])
        begin
            shield_nxt   = 1'b0;
            gate_nxt     = 1'b1; // R9 R10
            gate_cnt_nxt = 32'h0;
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            shield_r   <= 1'b0;
            gate_r     <= 1'b1;
            gate_cnt_r <= 32'h0;
        end
        else if (ce_i)
        begin
            shield_r   <= shield_nxt;
            gate_r     <= gate_nxt;
            gate_cnt_r <= gate_cnt_nxt;
        end
    end

    // ------------------------------------------------------------
    // attach state, retry timer and power switch
    // ------------------------------------------------------------
    always_comb
    begin
        st_nxt    = st_r;
        retry_nxt = retry_r;

        unique case (st_r)
            UPFS_ST_IDLE:
            begin
                retry_nxt = 32'h0;
                if (any_fault)
                    st_nxt = UPFS_ST_FAULT; // R16
                else if (holdup_above_lockout_i && sink_attached_i)
                    st_nxt = UPFS_ST_ON; // R17 R18
            end
            UPFS_ST_ON:
            begin
                if (any_fault)
                    st_nxt = UPFS_ST_FAULT; // R3 R5 R11 R12 R16
                else if (!holdup_above_lockout_i || !sink_attached_i)
                    st_nxt = UPFS_ST_IDLE;
            end
            UPFS_ST_FAULT:
            begin
                retry_nxt = 32'h0;
                st_nxt    = UPFS_ST_RETRY;
            end
            UPFS_ST_RETRY:
            begin
                if (cond_present || shield_r)
                    retry_nxt = 32'h0; // R20 R4 R6
                else if (retry_r >= 32'(RETRY_CYCLES - 1))
                    st_nxt = UPFS_ST_IDLE; // R4 R6 R13 R16
                else
                    retry_nxt = retry_r + 32'h1;
            end
        endcase

        // outputs follow the next state so they move with it
        sw_nxt   = (st_nxt == UPFS_ST_ON);
        arst_nxt = (st_nxt == UPFS_ST_FAULT) || (st_nxt == UPFS_ST_RETRY);
        flt_nxt  = arst_nxt; // R20
    end

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            st_r    <= UPFS_ST_IDLE;
            retry_r <= 32'h0;
            sw_r    <= 1'b0;
            arst_r  <= 1'b0;
            flt_r   <= 1'b0;
        end
        else if (ce_i)
        begin
            st_r    <= st_nxt;
            retry_r <= retry_nxt;
            sw_r    <= sw_nxt;
            arst_r  <= arst_nxt;
            flt_r   <= flt_nxt;
        end
    end

    // ------------------------------------------------------------
    // advertised current level
    // ------------------------------------------------------------
    always_comb
    begin
        // strap high: 3.0A unless discharging
        hi_nxt = current_level_select_i && !holdup_discharge_i; // R2
        lo_nxt = !hi_nxt; // R1
    end

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            hi_r <= 1'b0;
            lo_r <= 1'b1;
        end
        else if (ce_i)
        begin
            hi_r <= hi_nxt;
            lo_r <= lo_nxt;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign power_switch_o        = sw_r;
    assign attach_reset_o        = arst_r;
    assign ground_switch_gate_o  = gate_r;
    assign high_current_advert_o = hi_r;
    assign low_current_advert_o  = lo_r;
    assign fault_active_o        = flt_r;
endmodule

// ===== upfs_cfg.svh
// timing constants and the fault index map for the port fault supervisor
// assumes a 50 MHz core clock
`ifndef UPFS_CFG_SVH
`define UPFS_CFG_SVH
`define UPFS_CLK_MHZ        50
`define UPFS_SHORT_US       250
`define UPFS_OVERVOLT_US    1000
`define UPFS_SHIELD_US      4
`define UPFS_FWD_MS         50
`define UPFS_SEVERE_US      250
`define UPFS_THERM_US       100
`define UPFS_RETRY_MS       2000
`define UPFS_GATE_DELAY_US  4
`define UPFS_CYC_SHORT      (`UPFS_SHORT_US * `UPFS_CLK_MHZ + 1)
`define UPFS_CYC_OVERVOLT   (`UPFS_OVERVOLT_US * `UPFS_CLK_MHZ + 1)
`define UPFS_CYC_SHIELD     (`UPFS_SHIELD_US * `UPFS_CLK_MHZ)
`define UPFS_CYC_FWD        (`UPFS_FWD_MS * 1000 * `UPFS_CLK_MHZ)
`define UPFS_CYC_SEVERE     (`UPFS_SEVERE_US * `UPFS_CLK_MHZ)
`define UPFS_CYC_THERM      (`UPFS_THERM_US * `UPFS_CLK_MHZ + 1)
`define UPFS_CYC_RETRY      (`UPFS_RETRY_MS * 1000 * `UPFS_CLK_MHZ)
`define UPFS_CYC_GATE_DELAY (`UPFS_GATE_DELAY_US * `UPFS_CLK_MHZ)
`define UPFS_NUM_FAULTS     6
`define UPFS_F_SHORT        0
`define UPFS_F_OVERVOLT     1
`define UPFS_F_SHIELD       2
`define UPFS_F_FWD          3
`define UPFS_F_SEVERE       4
`define UPFS_F_THERM        5
`endif

// ===== upfs_pkg.sv
// types for the port fault supervisor
// assumes upfs_cfg.svh for numbers
package upfs_pkg;
    typedef enum logic [1:0] {
        UPFS_ST_IDLE     = 2'b00,
        UPFS_ST_ON       = 2'b01,
        UPFS_ST_FAULT    = 2'b10,
        UPFS_ST_RETRY    = 2'b11
    } upfs_state_t;
endpackage

// ===== upfs_debounce.sv
// one synchronised, debounced fault indication
// assumes the raw level is synchronous to core_clk_i; sync adds margin
`timescale 1ns/1ps
`include "upfs_cfg.svh"
module upfs_debounce #(
    parameter int CYCLES = 16
) (
    input  wire logic core_clk_i,
    input  wire logic rst_i,
    input  wire logic ce_i,
    input  wire logic raw_i,
    output logic      level_o
);
    import upfs_pkg::*;
    logic        sync1_r;
    logic        sync1_nxt;
    logic        sync2_r;
    logic        sync2_nxt;
    logic [31:0] cnt_r;
    logic [31:0] cnt_nxt;
    logic        lvl_r;
    logic        lvl_nxt;

    assign level_o = lvl_r;

    always_comb
    begin
        sync1_nxt = raw_i;
        sync2_nxt = sync1_r;
        cnt_nxt   = cnt_r;
        lvl_nxt   = lvl_r;
        if (!sync2_r)
        begin
            cnt_nxt = 32'h0; // R19
            lvl_nxt = 1'b0;
        end
        else if (cnt_r >= 32'(CYCLES - 1))
            lvl_nxt = 1'b1;
        else
            cnt_nxt = cnt_r + 32'h1;
    end

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
            cnt_r   <= 32'h0;
            lvl_r   <= 1'b0;
        end
        else if (ce_i)
        begin
            sync1_r <= sync1_nxt; // R19
            sync2_r <= sync2_nxt;
            cnt_r   <= cnt_nxt;
            lvl_r   <= lvl_nxt;
        end
    end
endmodule

// ===== upfs_port_model.sv
// far side model: upstream hold-up supply and attached sink terminations
// assumes the bench drives its commands on the rising core_clk_i edge
`timescale 1ns/1ps
module upfs_port_model (
    input  logic core_clk_i,
    input  logic plug_i,
    input  logic bias_up_i,
    input  logic brownout_i,
    output logic sink_attached_o = 1'b0,
    output logic holdup_above_lockout_o = 1'b0,
    output logic holdup_discharge_o = 1'b0
);
    always @(posedge core_clk_i)
    begin
        sink_attached_o        <= plug_i;
        holdup_above_lockout_o <= bias_up_i;
        holdup_discharge_o     <= brownout_i;
    end
endmodule

// ===== upfs_monitor.sv
// port checks for the fault supervisor, bound into upfs_top
// assumes every input changes on the rising core_clk_i edge
`timescale 1ns/1ps
module upfs_monitor #(
    parameter int RETRY_CYCLES = 1000,
    parameter int FWD_CYCLES   = 300
) (
    input  logic core_clk_i,
    input  logic rst_i,
    input  logic ce_i,
    input  logic current_level_select_i,
    input  logic holdup_discharge_i,
    input  logic holdup_above_lockout_i,
    input  logic sink_attached_i,
    input  logic short_to_ground_i,
    input  logic overvoltage_i,
    input  logic shield_sense_i,
    input  logic forward_current_i,
    input  logic severe_short_i,
    input  logic overtemp_i,
    input  logic power_switch_o,
    input  logic attach_reset_o,
    input  logic ground_switch_gate_o,
    input  logic high_current_advert_o,
    input  logic low_current_advert_o,
    input  logic fault_active_o
);
    logic        any_f;
    logic [31:0] quiet_r;
    logic [31:0] quiet_nxt;
    assign any_f = short_to_ground_i | overvoltage_i | shield_sense_i
                 | forward_current_i | severe_short_i | overtemp_i;
    // cycles since the last raw fault level
    always_comb
    begin
        quiet_nxt = (rst_i || any_f) ? 32'h0 : quiet_r + 32'h1;
    end
    always_ff @(posedge core_clk_i)
    begin
        quiet_r <= quiet_nxt;
    end
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    adv_compl_a: assert property (
        low_current_advert_o == !high_current_advert_o) else $error("advert");
    adv_follow_a: assert property (!$past(rst_i) && $past(ce_i) |->
        high_current_advert_o == $past(current_level_select_i
        && !holdup_discharge_i)) else $error("advert follow");
    sw_lockout_a: assert property ($rose(power_switch_o) |->
        holdup_above_lockout_i || $past(holdup_above_lockout_i))
        else $error("switch without lockout");
    sw_sink_a: assert property ($rose(power_switch_o) |->
        sink_attached_i || $past(sink_attached_i)) else $error("no sink");
    fault_off_a: assert property (attach_reset_o |-> !power_switch_o)
        else $error("switch closed in fault");
    gate_delay_a: assert property ($fell(ground_switch_gate_o) |->
        attach_reset_o && $past(attach_reset_o, 195)) else $error("gate");
    gate_back_a: assert property ($rose(ground_switch_gate_o) |->
        !shield_sense_i && !$past(shield_sense_i)) else $error("gate back");
    retry_wait_a: assert property ($fell(attach_reset_o) |->
        quiet_r >= RETRY_CYCLES) else $error("retry too short");
    trip_min_a: assert property ($rose(attach_reset_o) |->
        $past(any_f, 8) && $past(any_f, 150)) else $error("trip early");
    flag_match_a: assert property (
        fault_active_o == attach_reset_o) else $error("fault flag");
endmodule
bind upfs_top upfs_monitor #(.RETRY_CYCLES(RETRY_CYCLES),
    .FWD_CYCLES(FWD_CYCLES)) i_mon (.core_clk_i, .rst_i,
    .current_level_select_i, .holdup_discharge_i, .holdup_above_lockout_i,
    .sink_attached_i, .short_to_ground_i, .overvoltage_i, .shield_sense_i,
    .forward_current_i, .severe_short_i, .overtemp_i, .power_switch_o,
    .attach_reset_o, .ground_switch_gate_o, .high_current_advert_o,
    .low_current_advert_o, .ce_i, .fault_active_o);

// ===== upfs_tb_top.sv
// self-checking bench for the port fault supervisor
// assumes short retry and forward counts set below
`timescale 1ns/1ps
`include "upfs_cfg.svh"
module upfs_tb_top;
    localparam int RET = 1000;
    localparam int FWD = 300;
    logic       core_clk_i = 1'b0;
    logic       rst_i = 1'b1;
    logic       ce_i = 1'b1;
    logic       current_level_select_i = 1'b0;
    logic       below_recover_temp_i = 1'b1;
    logic       plug = 1'b0;
    logic       bias_up = 1'b0;
    logic       brownout = 1'b0;
    logic [5:0] flt = 6'h00;
    logic       sink_attached_i, holdup_above_lockout_i, holdup_discharge_i;
    logic       power_switch_o, attach_reset_o, ground_switch_gate_o;
    logic       high_current_advert_o, low_current_advert_o;
    logic       fault_active_o;
    logic [2:0] obs;
    int         miscompares = 0;
    int         cmp_count = 0;
    assign obs = {ground_switch_gate_o, attach_reset_o, power_switch_o};
    upfs_top #(.RETRY_CYCLES(RET), .FWD_CYCLES(FWD)) i_dut (
        .core_clk_i, .rst_i, .ce_i, .current_level_select_i,
        .holdup_discharge_i, .holdup_above_lockout_i, .sink_attached_i,
        .short_to_ground_i(flt[`UPFS_F_SHORT]),
        .overvoltage_i(flt[`UPFS_F_OVERVOLT]),
        .shield_sense_i(flt[`UPFS_F_SHIELD]),
        .forward_current_i(flt[`UPFS_F_FWD]),
        .severe_short_i(flt[`UPFS_F_SEVERE]),
        .overtemp_i(flt[`UPFS_F_THERM]), .below_recover_temp_i,
        .power_switch_o, .attach_reset_o, .ground_switch_gate_o,
        .high_current_advert_o, .low_current_advert_o, .fault_active_o);
    upfs_port_model i_port (.core_clk_i, .plug_i(plug), .bias_up_i(bias_up),
        .brownout_i(brownout), .sink_attached_o(sink_attached_i),
        .holdup_above_lockout_o(holdup_above_lockout_i),
        .holdup_discharge_o(holdup_discharge_i));
    initial
    begin
        forever #10 core_clk_i = ~core_clk_i;
    end
    task automatic end_sim();
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(string what, logic [31:0] got, logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("wrong value %s exp %0h seen %0h", what, exp, got);
        end
    endtask
    task automatic cyc(int k);
        repeat (k) @(negedge core_clk_i);
    endtask
    // wait for one output bit, counting falling edges
    task automatic wait_on(int s, logic v, int lim, output int n);
        for (n = 0; n < lim && obs[s] !== v; n++)
            @(negedge core_clk_i);
        if (obs[s] !== v)
        begin
            miscompares++;
            end_sim();
        end
    endtask
    task automatic trip(int f, int deb);
        int n;
        @(posedge core_clk_i);
        flt[f] <= 1'b1;
        wait_on(0, 1'b0, deb + 12, n);
        chk("trip time", n >= deb, 1'b1);
        chk("attach reset", attach_reset_o, 1'b1);
        chk("fault flag", fault_active_o, 1'b1);
        @(posedge core_clk_i);
        flt[f] <= 1'b0;
        wait_on(0, 1'b1, RET + 40, n);
        chk("retry wait", n >= RET, 1'b1);
        chk("fault clear", fault_active_o, 1'b0);
    endtask
    task automatic t_power_gate();
        int n;
        @(posedge core_clk_i);
        plug <= 1'b1;
        cyc(20);
        chk("switch no bias", power_switch_o, 1'b0);
        @(posedge core_clk_i);
        plug <= 1'b0;
        bias_up <= 1'b1;
        cyc(20);
        chk("switch no sink", power_switch_o, 1'b0);
        @(posedge core_clk_i);
        plug <= 1'b1;
        wait_on(0, 1'b1, 10, n);
    endtask
    task automatic t_advert();
        for (int i = 0; i < 4; i++)
        begin
            @(posedge core_clk_i);
            current_level_select_i <= i[0];
            brownout <= i[1];
            cyc(4);
            chk("high advert", high_current_advert_o, i == 1);
            chk("low advert", low_current_advert_o, i != 1);
        end
        // clock enable low must freeze the advert
        @(posedge core_clk_i);
        ce_i     <= 1'b0;
        brownout <= 1'b0;
        cyc(4);
        chk("frozen advert", high_current_advert_o, 1'b0);
        @(posedge core_clk_i);
        ce_i <= 1'b1;
        cyc(4);
        chk("thawed advert", high_current_advert_o, 1'b1);
    endtask
    task automatic t_forward();
        @(posedge core_clk_i);
        flt[`UPFS_F_FWD] <= 1'b1;
        cyc(FWD - 20);
        @(posedge core_clk_i);
        flt[`UPFS_F_FWD] <= 1'b0;
        trip(`UPFS_F_FWD, FWD);
    endtask
    task automatic t_thermal();
        int n;
        @(posedge core_clk_i);
        flt[`UPFS_F_THERM] <= 1'b1;
        below_recover_temp_i <= 1'b0;
        wait_on(0, 1'b0, 5015, n);
        chk("hot trip", n >= 5001, 1'b1);
        @(posedge core_clk_i);
        flt[`UPFS_F_THERM] <= 1'b0;
        cyc(RET + 100);
        chk("still hot", power_switch_o, 1'b0);
        @(posedge core_clk_i);
        below_recover_temp_i <= 1'b1;
        wait_on(0, 1'b1, 5001 + RET + 40, n);
        chk("cool wait", n >= 5001 + RET, 1'b1);
    endtask
    task automatic t_shield();
        int n;
        @(posedge core_clk_i);
        flt[`UPFS_F_SHIELD] <= 1'b1;
        wait_on(1, 1'b1, 220, n);
        wait_on(2, 1'b0, 220, n);
        chk("gate delay", n >= 198 && n <= 201, 1'b1);
        @(posedge core_clk_i);
        flt[`UPFS_F_SHIELD] <= 1'b0;
        wait_on(2, 1'b1, 8, n);
        chk("attach held", attach_reset_o, 1'b1);
        wait_on(0, 1'b1, RET + 40, n);
        chk("shield retry", n >= RET, 1'b1);
    endtask
    initial
    begin
        repeat (2) @(posedge core_clk_i);
        rst_i <= 1'b0;
        t_advert();
        t_power_gate();
        trip(`UPFS_F_SHORT, 12501);
        trip(`UPFS_F_OVERVOLT, 50001);
        trip(`UPFS_F_SEVERE, 12500);
        t_forward();
        t_thermal();
        t_shield();
        end_sim();
    end
endmodule
